// ---- verilog/pin_ctl_pkg.sv ----
// shared constants for the pin, mode and reset control block
package pin_ctl_pkg;

  // operating modes, strap code is {strap_high_bit, strap_low_bit}
  typedef enum logic [1:0]
  {
    MODE_BOOTSTRAP = 2'h0,
    MODE_TEST      = 2'h1,
    MODE_SINGLE    = 2'h2,
    MODE_EXPANDED  = 2'h3
  } op_mode_type;

  // register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS   = 8'h08;
  localparam logic [7:0] MODE_OFS   = 8'h0C;
  localparam logic [7:0] CONFIG_OFS = 8'h10;

  // control register fields
  localparam int CTRL_EDGE_BIT   = 0;
  localparam int CTRL_XMASK_BIT  = 1;
  localparam int CTRL_CLKMON_BIT = 2;

  // status and mask fields
  localparam int EV_WATCHDOG = 0;
  localparam int EV_CLKFAIL  = 1;
  localparam int EV_ILLEGAL  = 2;
  localparam int EV_EXTRESET = 3;
  localparam int EV_W        = 4;

  // nonvolatile configuration fields and shipped value
  localparam int CFG_EEPROM_BIT = 0;
  localparam int CFG_ROM_BIT    = 1;
  localparam logic [7:0] CFG_RESET_VALUE = 8'h0F;

  // oscillator to bus phase clock ratio
  localparam int E_DIVIDE = 4;

  // reset values
  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;
  localparam logic [2:0] CTRL_RESET = 3'h2;

  // pin counts moved to the multiplexed bus in expanded mode
  localparam int EXP_BUS_PINS = 18;

  // times and their cycle counts at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_DRIVE_NS  = 160;
  localparam int CLKMON_NS     = 10000;
  localparam int RST_DRIVE_CYC =
    (RST_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLKMON_CYC    = CLKMON_NS / CLK_PERIOD_NS;

endpackage

// ---- verilog/sync_2ff.sv ----
// two flip-flop synchroniser for pin inputs
module sync_2ff
#(
  parameter int         WIDTH = 1,
  parameter logic [0:0] INIT  = 1'h1
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage is read only by the second
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1   <= {WIDTH{INIT}};
      sync_out <= {WIDTH{INIT}};
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ---- verilog/phase_clk_div.sv ----
// divides the oscillator clock into the bus phase clock
module phase_clk_div
#(
  parameter int DIVIDE = 4
)
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic halt,
  output logic      e_clk,
  output logic      e_fall_en
);

  localparam int CW = $clog2(DIVIDE);
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);
  localparam logic [CW-1:0] HALF = CW'(DIVIDE / 2);

  logic [CW-1:0] phase;
  logic [CW-1:0] next_phase;
  logic          next_e_clk;
  logic          next_e_fall_en;

  // phase counter frozen while halted, so the clock stops toggling
  always_comb
  begin
    next_phase     = phase;
    next_e_clk     = e_clk;
    next_e_fall_en = 1'b0;
    if (!halt)
    begin
      next_phase     = (phase == LAST) ? '0 : phase + CW'(1);
      next_e_clk     = (next_phase >= HALF);
      next_e_fall_en = (phase == LAST);
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase     <= '0;
      e_clk     <= 1'b0;
      e_fall_en <= 1'b0;
    end
    else
    begin
      phase     <= next_phase;
      e_clk     <= next_e_clk;
      e_fall_en <= next_e_fall_en;
    end
  end

endmodule

// ---- verilog/mcu_pin_mode_reset_control.sv ----
// pin, operating mode, interrupt pin and reset control with AXI4-Lite
module mcu_pin_mode_reset_control
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              osc_input,
  input  wire logic              reset_pin_in,
  output logic                   reset_pin_out,
  output logic                   reset_pin_oe,
  input  wire logic              strap_low_bit,
  input  wire logic              strap_high_bit,
  output logic                   instr_start_out,
  output logic                   instr_start_oe,
  input  wire logic              irq_n_pin,
  input  wire logic              nonmaskable_irq_in,
  input  wire logic              irq_ack,
  input  wire logic              halt_mode,
  input  wire logic              opcode_fetch,
  input  wire logic              illegal_opcode,
  input  wire logic              watchdog_fail,
  input  wire logic              write_cycle,
  output logic                   e_clk,
  output logic                   e_fall_en,
  output logic                   sys_reset,
  output logic [1:0]             op_mode,
  output logic                   expanded_bus_en,
  output logic                   rw_out,
  output logic                   data_strobe,
  output logic                   irq_request,
  output logic                   nonmaskable_irq_in_request,
  output logic                   illegal_nmi,
  output logic                   rom_enable,
  output logic                   eeprom_enable,
  output logic                   irq_out
);

  typedef enum logic [1:0]
  {
    RP_IDLE,
    RP_DRIVE,
    RP_RECOVER
  } rst_pin_state_type;

  localparam int EW = pin_ctl_pkg::EV_W;
  localparam int DW = $clog2(pin_ctl_pkg::RST_DRIVE_CYC + 1);
  localparam int MW = $clog2(pin_ctl_pkg::CLKMON_CYC + 1);
  localparam logic [DW-1:0] DRIVE_LAST =
    DW'(pin_ctl_pkg::RST_DRIVE_CYC - 1);
  localparam logic [MW-1:0] MON_LAST = MW'(pin_ctl_pkg::CLKMON_CYC - 1);

  // pin synchronisers
  logic [5:0] pin_sync;
  logic       rst_pin_s;
  logic       osc_s;
  logic       strap_lo_s;
  logic       strap_hi_s;
  logic       irq_n_s;
  logic       nonmaskable_irq_in_n_s;

  sync_2ff #(.WIDTH(6), .INIT(1'h1)) u_sync
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({reset_pin_in, osc_input, strap_low_bit, strap_high_bit,
                irq_n_pin, nonmaskable_irq_in}),
    .sync_out (pin_sync)
  );

  assign {rst_pin_s, osc_s, strap_lo_s, strap_hi_s, irq_n_s, nonmaskable_irq_in_n_s} =
    pin_sync;

  // bus phase clock, frozen in halt mode
  phase_clk_div #(.DIVIDE(pin_ctl_pkg::E_DIVIDE)) u_div
  (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .halt      (halt_mode),
    .e_clk     (e_clk),
    .e_fall_en (e_fall_en)
  );

  // state
  rst_pin_state_type rp_state;
  rst_pin_state_type next_rp_state;
  logic [DW-1:0]     drive_cnt;
  logic [DW-1:0]     next_drive_cnt;
  logic [MW-1:0]     mon_cnt;
  logic [MW-1:0]     next_mon_cnt;
  logic              osc_q;
  logic              sys_reset_q;
  logic [1:0]        warm;
  logic [1:0]        next_op_mode;
  logic              mode_valid;
  logic              next_mode_valid;
  logic [2:0]        ctrl;
  logic [2:0]        next_ctrl;
  logic [EW-1:0]     status;
  logic [EW-1:0]     next_status;
  logic [EW-1:0]     mask;
  logic [EW-1:0]     next_mask;
  logic [7:0]        cfg_prog;
  logic [7:0]        next_cfg_prog;
  logic [7:0]        cfg_active;
  logic [7:0]        next_cfg_active;
  logic              irq_n_q;
  logic              irq_pend;
  logic              next_irq_pend;
  logic              clk_fail;
  logic              fail;
  logic [EW-1:0]     events;
  logic              wr_go;
  logic              rd_go;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic [1:0]        next_bresp;
  logic              next_bvalid;
  logic              next_rvalid;
  logic              next_rw_out;
  logic              next_instr_oe;
  logic              next_illegal_nmi;

  // clock monitor: oscillator pin must toggle within the timeout
  assign clk_fail = ctrl[pin_ctl_pkg::CTRL_CLKMON_BIT] &&
                    (mon_cnt == MON_LAST);
  assign fail = clk_fail | watchdog_fail;
  assign events = {(rp_state == RP_IDLE) & ~rst_pin_s, illegal_opcode,
                   clk_fail, watchdog_fail};

  // reset pin driver and clock monitor counters
  always_comb
  begin
    next_rp_state  = rp_state;
    next_drive_cnt = drive_cnt;
    next_mon_cnt   = (osc_s != osc_q || mon_cnt == MON_LAST) ?
                     '0 : mon_cnt + MW'(1);
    case (rp_state)
      RP_IDLE:
      begin
        if (fail)
        begin
          next_rp_state  = RP_DRIVE;
          next_drive_cnt = '0;
        end
      end
      RP_DRIVE:
      begin
        next_drive_cnt = drive_cnt + DW'(1);
        if (drive_cnt == DRIVE_LAST)
          next_rp_state = RP_RECOVER;
      end
      RP_RECOVER:
      begin
        if (rst_pin_s)
          next_rp_state = RP_IDLE;
      end
      default:
        next_rp_state = RP_IDLE;
    endcase
  end

  // system reset from the pin or our own drive; also held until the pin
  // synchronisers have filled, so straps are never taken from their init
  assign sys_reset = ~rst_pin_s | (rp_state != RP_IDLE) |
                     ~warm[1];
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = (rp_state == RP_DRIVE);

  // strap latch, config reload and mode dependent pins
  always_comb
  begin
    next_op_mode    = op_mode;
    next_mode_valid = mode_valid;
    next_cfg_active = cfg_active;
    if (sys_reset)
      next_mode_valid = 1'b0;
    else if (sys_reset_q)
    begin
      next_op_mode    = {strap_hi_s, strap_lo_s};
      next_mode_valid = 1'b1;
      next_cfg_active = cfg_prog;
    end
    next_rw_out = 1'b1;
    if (op_mode == pin_ctl_pkg::MODE_EXPANDED && mode_valid)
      next_rw_out = ~write_cycle;
    next_instr_oe    = mode_valid & opcode_fetch;
    next_illegal_nmi = illegal_opcode;
  end

  assign expanded_bus_en = mode_valid &&
    (op_mode == pin_ctl_pkg::MODE_EXPANDED);
  assign data_strobe = expanded_bus_en & e_clk;
  assign instr_start_out = 1'b0;
  assign rom_enable = cfg_active[pin_ctl_pkg::CFG_ROM_BIT];
  assign eeprom_enable = cfg_active[pin_ctl_pkg::CFG_EEPROM_BIT];

  // maskable and nonmaskable interrupt pins
  always_comb
  begin
    next_irq_pend = irq_pend;
    if (sys_reset || !ctrl[pin_ctl_pkg::CTRL_EDGE_BIT])
      next_irq_pend = 1'b0;
    else if (irq_n_q && !irq_n_s)
      next_irq_pend = 1'b1;
    else if (irq_ack)
      next_irq_pend = 1'b0;
  end

  assign irq_request = ctrl[pin_ctl_pkg::CTRL_EDGE_BIT] ?
                       irq_pend : ~irq_n_s;
  assign nonmaskable_irq_in_request = ~nonmaskable_irq_in_n_s &
                        ~ctrl[pin_ctl_pkg::CTRL_XMASK_BIT];

  // AXI4-Lite slave: write needs address and data together
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go = s_axi_awready;
  assign rd_go = s_axi_arvalid & s_axi_arready;

  // register file next values
  always_comb
  begin
    next_ctrl     = ctrl;
    next_mask     = mask;
    next_cfg_prog = cfg_prog;
    next_status   = status;
    next_bresp    = s_axi_bresp;
    next_bvalid   = s_axi_bvalid & ~s_axi_bready;
    next_rvalid   = s_axi_rvalid & ~s_axi_rready;
    next_rdata    = s_axi_rdata;
    next_rresp    = s_axi_rresp;
    if (wr_go)
    begin
      next_bvalid = 1'b1;
      next_bresp  = 2'h0;
      case (s_axi_awaddr)
        pin_ctl_pkg::CTRL_OFS:
        begin
          if (s_axi_wstrb[0])
          begin
            next_ctrl[pin_ctl_pkg::CTRL_EDGE_BIT] =
              s_axi_wdata[pin_ctl_pkg::CTRL_EDGE_BIT];
            next_ctrl[pin_ctl_pkg::CTRL_CLKMON_BIT] =
              s_axi_wdata[pin_ctl_pkg::CTRL_CLKMON_BIT];
            if (!s_axi_wdata[pin_ctl_pkg::CTRL_XMASK_BIT])
              next_ctrl[pin_ctl_pkg::CTRL_XMASK_BIT] = 1'b0;
          end
        end
        pin_ctl_pkg::MASK_OFS:
        begin
          if (s_axi_wstrb[0])
            next_mask = s_axi_wdata[EW-1:0];
        end
        pin_ctl_pkg::CONFIG_OFS:
        begin
          if (s_axi_wstrb[0])
            next_cfg_prog = s_axi_wdata[7:0];
        end
        pin_ctl_pkg::STATUS_OFS, pin_ctl_pkg::MODE_OFS: ;
        default:
          next_bresp = 2'h2;
      endcase
    end
    if (rd_go)
    begin
      next_rvalid = 1'b1;
      next_rresp  = 2'h0;
      next_rdata  = 32'h0;
      case (s_axi_araddr)
        pin_ctl_pkg::CTRL_OFS:   next_rdata = {29'h0, ctrl};
        pin_ctl_pkg::STATUS_OFS:
        begin
          next_rdata  = {28'h0, status};
          next_status = '0;
        end
        pin_ctl_pkg::MASK_OFS:   next_rdata = {28'h0, mask};
        pin_ctl_pkg::MODE_OFS:
          next_rdata = {21'h0, mode_valid, cfg_active, op_mode};
        pin_ctl_pkg::CONFIG_OFS: next_rdata = {24'h0, cfg_prog};
        default:                 next_rresp = 2'h2;
      endcase
    end
    next_status = next_status | events; // set wins over read clear
    if (sys_reset)
    begin
      next_ctrl[pin_ctl_pkg::CTRL_EDGE_BIT]  = 1'b0;
      next_ctrl[pin_ctl_pkg::CTRL_XMASK_BIT] = 1'b1;
    end
  end

  // all registered state
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rp_state       <= RP_IDLE;
      drive_cnt      <= '0;
      mon_cnt        <= '0;
      osc_q          <= 1'b1;
      sys_reset_q    <= 1'b1;
      warm           <= 2'h0;
      op_mode        <= 2'h0;
      mode_valid     <= 1'b0;
      cfg_prog       <= pin_ctl_pkg::CFG_RESET_VALUE;
      cfg_active     <= pin_ctl_pkg::CFG_RESET_VALUE;
      ctrl           <= pin_ctl_pkg::CTRL_RESET;
      status         <= '0;
      mask           <= pin_ctl_pkg::MASK_RESET;
      irq_n_q        <= 1'b1;
      irq_pend       <= 1'b0;
      rw_out         <= 1'b1;
      instr_start_oe <= 1'b0;
      illegal_nmi    <= 1'b0;
      irq_out        <= 1'b0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= 2'h0;
      s_axi_rvalid   <= 1'b0;
      s_axi_rresp    <= 2'h0;
      s_axi_rdata    <= 32'h0;
    end
    else
    begin
      rp_state       <= next_rp_state;
      drive_cnt      <= next_drive_cnt;
      mon_cnt        <= next_mon_cnt;
      osc_q          <= osc_s;
      sys_reset_q    <= sys_reset;
      warm           <= {warm[0], 1'b1};
      op_mode        <= next_op_mode;
      mode_valid     <= next_mode_valid;
      cfg_prog       <= next_cfg_prog;
      cfg_active     <= next_cfg_active;
      ctrl           <= next_ctrl;
      status         <= next_status;
      mask           <= next_mask;
      irq_n_q        <= irq_n_s;
      irq_pend       <= next_irq_pend;
      rw_out         <= next_rw_out;
      instr_start_oe <= next_instr_oe;
      illegal_nmi    <= next_illegal_nmi;
      irq_out        <= |(next_status & next_mask);
      s_axi_bvalid   <= next_bvalid;
      s_axi_bresp    <= next_bresp;
      s_axi_rvalid   <= next_rvalid;
      s_axi_rresp    <= next_rresp;
      s_axi_rdata    <= next_rdata;
    end
  end

endmodule

// ---- verif/pin_ctl_board.sv ----
// model of the board circuitry around reset, strap and interrupt pins
module pin_ctl_board
(
  input  wire logic       ref_clk,
  input  wire logic       reset_pin_out,
  input  wire logic       reset_pin_oe,
  input  wire logic       instr_start_out,
  input  wire logic       instr_start_oe,
  input  wire logic       hold_reset,
  input  wire logic       osc_run,
  input  wire logic       irq_low,
  input  wire logic       nonmaskable_irq_in_low,
  input  wire logic [1:0] strap_code,
  output logic            reset_pin_in,
  output logic            strap_low_bit,
  output logic            strap_high_bit,
  output logic            irq_n_pin,
  output logic            nonmaskable_irq_in,
  output logic            osc_input = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;

  // pulled-up reset wire, low from the board or from the device driver
  assign reset_pin_in =
    !(hold_reset || (reset_pin_oe && !reset_pin_out));
  // strap jumpers, the low one shares its pin with the open-drain marker
  assign strap_high_bit = strap_code[1];
  assign strap_low_bit =
    strap_code[0] && !(instr_start_oe && !instr_start_out);
  // request lines with pull-ups
  assign irq_n_pin = !irq_low;
  assign nonmaskable_irq_in = !nonmaskable_irq_in_low;
  // oscillator activity stands still while stopped
  always @(posedge ref_clk)
    if (osc_run) osc_input <= !osc_input;
endmodule

// ---- verif/pin_ctl_properties.sv ----
// port checker for the pin, mode and reset control block
module pin_ctl_properties
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       halt_mode,
  input wire logic       opcode_fetch,
  input wire logic       illegal_opcode,
  input wire logic       watchdog_fail,
  input wire logic       write_cycle,
  input wire logic       e_clk,
  input wire logic       e_fall_en,
  input wire logic       sys_reset,
  input wire logic [1:0] op_mode,
  input wire logic       expanded_bus_en,
  input wire logic       rw_out,
  input wire logic       data_strobe,
  input wire logic       nonmaskable_irq_in_request,
  input wire logic       illegal_nmi,
  input wire logic       reset_pin_oe,
  input wire logic       instr_start_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // phase steps, the reset pin drive run and the settled run state
  sequence e_high_phase; e_clk ##1 e_clk; endsequence
  sequence drive_8; reset_pin_oe [*8]; endsequence
  sequence up_idle; !sys_reset [*4]; endsequence

  chk_eclk_quarter: assert property (disable iff (!rst_n || halt_mode)
    $rose(e_clk) |-> e_high_phase ##1 !e_clk ##1 !e_clk ##1 e_clk)
    else $error("phase clock not a quarter of the input");
  chk_eclk_frozen: assert property (halt_mode [*3] |-> $stable(e_clk))
    else $error("phase clock moves while halted");
  chk_fall_marker: assert property ($fell(e_clk) |-> e_fall_en)
    else $error("falling marker missing");
  chk_strobe_phase: assert property (
    data_strobe |-> e_clk && op_mode == 2'h3)
    else $error("data strobe outside high phase");
  chk_mode_static: assert property (up_idle |-> $stable(op_mode))
    else $error("mode changed outside reset");
  chk_fetch_marker: assert property (
    up_idle |=> instr_start_oe == $past(opcode_fetch))
    else $error("instruction start marker wrong");
  chk_drive_span: assert property (watchdog_fail && !sys_reset
    |=> drive_8 ##1 drive_8 ##1 !reset_pin_oe)
    else $error("reset pin drive length wrong");
  chk_drive_resets: assert property (reset_pin_oe |-> sys_reset)
    else $error("pin drive without system reset");
  chk_nmi_trap: assert property (illegal_opcode |=> illegal_nmi)
    else $error("illegal opcode gave no interrupt");
  chk_nonmaskable_irq_in_blocked: assert property (sys_reset |=> !nonmaskable_irq_in_request)
    else $error("nonmaskable request open after reset");
  chk_bus_dir: assert property (expanded_bus_en ##1 expanded_bus_en
    |-> rw_out == !$past(write_cycle))
    else $error("direction output wrong");
endmodule

bind mcu_pin_mode_reset_control pin_ctl_properties pin_ctl_properties_inst
(
  .ref_clk, .rst_n, .halt_mode, .opcode_fetch, .illegal_opcode,
  .watchdog_fail, .write_cycle, .e_clk, .e_fall_en, .sys_reset, .op_mode,
  .expanded_bus_en, .rw_out, .data_strobe, .nonmaskable_irq_in_request, .illegal_nmi,
  .reset_pin_oe, .instr_start_oe
);

// ---- verif/tb_mcu_pin_mode_reset_control.sv ----
// testbench for the pin, mode and reset control block
module tb_mcu_pin_mode_reset_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'h0, rst_n = 1'h0, hold_reset = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1, irq_ack = 1'h0;
  logic        halt_mode = 1'h0, opcode_fetch = 1'h0, illegal_opcode = 1'h0;
  logic        watchdog_fail = 1'h0, write_cycle = 1'h0, osc_run = 1'h1;
  logic        irq_low = 1'h0, nonmaskable_irq_in_low = 1'h0, e_prev;
  logic [1:0]  strap_code = 2'h0, s_axi_bresp, s_axi_rresp, op_mode, r;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, osc_input, reset_pin_in, reset_pin_out;
  logic        reset_pin_oe, strap_low_bit, strap_high_bit, instr_start_out;
  logic        instr_start_oe, irq_n_pin, nonmaskable_irq_in, e_clk;
  logic        sys_reset, expanded_bus_en, rw_out, irq_request, nonmaskable_irq_in_request;
  logic        rom_enable, eeprom_enable, irq_out, data_strobe;
  logic [7:0]  cfg_tab [4] = '{8'h0F, 8'h0D, 8'h0C, 8'h0F};
  int          miscompares = 0, checks_done = 0, n, k;

  mcu_pin_mode_reset_control mcu_pin_mode_reset_control_inst
  (
    .ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .osc_input, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .strap_low_bit,
    .strap_high_bit, .instr_start_out, .instr_start_oe, .irq_n_pin,
    .nonmaskable_irq_in, .irq_ack, .halt_mode, .opcode_fetch,
    .illegal_opcode, .watchdog_fail, .write_cycle, .e_clk, .e_fall_en(),
    .sys_reset, .op_mode, .expanded_bus_en, .rw_out, .data_strobe,
    .irq_request, .nonmaskable_irq_in_request, .illegal_nmi(), .rom_enable, .eeprom_enable,
    .irq_out
  );

  pin_ctl_board pin_ctl_board_inst
  (
    .ref_clk, .reset_pin_out, .reset_pin_oe, .instr_start_out,
    .instr_start_oe, .hold_reset, .osc_run, .irq_low, .nonmaskable_irq_in_low, .strap_code,
    .reset_pin_in, .strap_low_bit, .strap_high_bit, .irq_n_pin,
    .nonmaskable_irq_in, .osc_input
  );

  // clock
  always #5 ref_clk = !ref_clk;

  // compares and counts
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // bus write, entered just after a rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    @(negedge ref_clk);
    while (!s_axi_awready) @(negedge ref_clk);
    @(posedge ref_clk);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    @(negedge ref_clk);
    while (!s_axi_bvalid) @(negedge ref_clk);
    r = s_axi_bresp;
    @(posedge ref_clk);
  endtask

  // bus read, entered just after a rising edge
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    @(negedge ref_clk);
    while (!s_axi_arready) @(negedge ref_clk);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'h0;
    @(negedge ref_clk);
    while (!s_axi_rvalid) @(negedge ref_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge ref_clk);
  endtask

  // waits out system reset, then lets the mode latch settle
  task automatic await_run;
    @(negedge ref_clk);
    while (sys_reset) @(negedge ref_clk);
    repeat (3) @(posedge ref_clk);
  endtask

  // pulse on the reset pin from the board
  task automatic ext_reset;
    hold_reset <= 1'h1;
    repeat (6) @(posedge ref_clk);
    hold_reset <= 1'h0;
    await_run();
  endtask

  // lets a stimulus settle; callers compare at the rising edge it ends on,
  // where every output still shows its settled value from before the edge
  task automatic settle;
    repeat (5) @(posedge ref_clk);
  endtask

  // verdict and end of run
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard
  initial
  begin
    #200000;
    miscompares++;
    give_verdict();
  end

  // test sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    hold_reset <= 1'h0;
    await_run();
    check(op_mode, 32'h0);
    axi_rd(pin_ctl_pkg::CTRL_OFS);
    check(d, {29'h0, pin_ctl_pkg::CTRL_RESET});
    axi_rd(pin_ctl_pkg::MASK_OFS);
    check(d, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      strap_code <= 2'(i);
      axi_wr(pin_ctl_pkg::CONFIG_OFS, {24'h0, cfg_tab[i]});
      ext_reset();
      check(op_mode, 32'(i));
      check(expanded_bus_en, i == 3);
      check({rom_enable, eeprom_enable}, cfg_tab[i][1:0]);
      axi_rd(pin_ctl_pkg::MODE_OFS);
      check(d, {21'h0, 1'h1, cfg_tab[i], 2'(i)});
      axi_rd(pin_ctl_pkg::STATUS_OFS);
      check(d, 32'h8);
    end
    write_cycle <= 1'h1;
    opcode_fetch <= 1'h1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check(rw_out, 1'h0);
    check(instr_start_oe, 1'h1);
    @(posedge ref_clk);
    write_cycle <= 1'h0;
    opcode_fetch <= 1'h0;
    n = 0;
    k = 0;
    e_prev = e_clk;
    repeat (40)
    begin
      @(negedge ref_clk);
      n += int'(e_clk && !e_prev);
      k += int'(data_strobe);
      e_prev = e_clk;
    end
    check(n, 40 / pin_ctl_pkg::E_DIVIDE);
    check(k, 20);
    check(rw_out, 1'h1);
    @(posedge ref_clk);
    halt_mode <= 1'h1;
    repeat (3) @(posedge ref_clk);
    e_prev = e_clk;
    settle();
    check(e_clk, e_prev);
    halt_mode <= 1'h0;
    irq_low <= 1'h1;
    nonmaskable_irq_in_low <= 1'h1;
    settle();
    check(irq_request, 1'h1);
    check(nonmaskable_irq_in_request, 1'h0);
    irq_low <= 1'h0;
    settle();
    check(irq_request, 1'h0);
    axi_wr(pin_ctl_pkg::CTRL_OFS, 32'h1);
    settle();
    check(nonmaskable_irq_in_request, 1'h1);
    nonmaskable_irq_in_low <= 1'h0;
    irq_low <= 1'h1;
    @(posedge ref_clk);
    irq_low <= 1'h0;
    settle();
    check(irq_request, 1'h1);
    irq_ack <= 1'h1;
    @(posedge ref_clk);
    irq_ack <= 1'h0;
    settle();
    check(irq_request, 1'h0);
    for (int m = 0; m < 2; m++)
    begin
      axi_wr(pin_ctl_pkg::MASK_OFS, m ? 32'h0 : 32'h4);
      illegal_opcode <= 1'h1;
      @(posedge ref_clk);
      illegal_opcode <= 1'h0;
      settle();
      check(irq_out, m == 0);
      axi_rd(pin_ctl_pkg::STATUS_OFS);
      check(d, 32'h4);
      settle();
      check(irq_out, 1'h0);
    end
    watchdog_fail <= 1'h1;
    @(posedge ref_clk);
    watchdog_fail <= 1'h0;
    @(negedge ref_clk);
    n = 0;
    while (reset_pin_oe)
    begin
      n++;
      @(negedge ref_clk);
    end
    check(n, pin_ctl_pkg::RST_DRIVE_CYC);
    await_run();
    axi_rd(pin_ctl_pkg::STATUS_OFS);
    check(d & 32'h1, 32'h1);
    axi_wr(pin_ctl_pkg::CTRL_OFS, 32'h4);
    osc_run <= 1'h0;
    n = 0;
    while (!reset_pin_oe && n < 1200)
    begin
      n++;
      @(negedge ref_clk);
    end
    check(reset_pin_oe, 1'h1);
    @(posedge ref_clk);
    osc_run <= 1'h1;
    await_run();
    axi_rd(pin_ctl_pkg::STATUS_OFS);
    check(d & 32'h2, 32'h2);
    axi_rd(8'h40);
    check(d, 32'h0);
    check({30'h0, r}, 32'h2);
    axi_wr(8'h40, 32'h5);
    check(r, 2'h2);
    give_verdict();
  end
endmodule
